// ===== design/twr_pkg.sv
// Shared constants for the three-wire run control block
package twr_pkg;
  // Terminal control mode code selecting the three-wire scheme
  localparam logic [2:0] MODE_THREE_WIRE = 3'h2;
  localparam int MODE_W = 3;
  // Rotation direction encoding
  localparam logic DIR_FWD = 1'h0;
  localparam logic DIR_REV = 1'h1;
  // Reset values
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic RUN_RST = 1'h0;
endpackage

// ===== design/twr_sync_if.sv
// Interface carrying synchronised terminal levels between modules
`timescale 1ns/1ps
`default_nettype none
interface twr_sync_if;
  logic enable_closed;
  logic trigger_level;
  logic direction_level;
  modport src (output enable_closed, output trigger_level, output direction_level);
  modport dst (input enable_closed, input trigger_level, input direction_level);
endinterface
`default_nettype wire

// ===== design/twr_sync.sv
// Two-flop synchronisers for the three terminal inputs
`timescale 1ns/1ps
`default_nettype none
module twr_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Raw terminals
  input wire logic run_enable_terminal,
  input wire logic run_trigger_terminal,
  input wire logic direction_terminal,
  // Synchronised levels
  twr_sync_if.src sync
);
  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } twr_sync_state_t;

  twr_sync_state_t state_ff;
  twr_sync_state_t nxt_state;
  logic [2:0] raw;

  assign raw = {direction_terminal, run_trigger_terminal, run_enable_terminal};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.stage1 = raw; // [R7]
    nxt_state.stage2 = state_ff.stage1; // [R7]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign sync.enable_closed = state_ff.stage2[0];
  assign sync.trigger_level = state_ff.stage2[1];
  assign sync.direction_level = state_ff.stage2[2];

  // Levels reach the logic exactly two edges after the pins are sampled
  sync_depth_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    ($past(rst_n, 2) && $past(rst_n)) |-> (state_ff.stage2 == $past(raw, 2)))
    else $error("synchroniser depth wrong");
endmodule
`default_nettype wire

// ===== design/twr_run_ctrl.sv
// Three-wire run and direction command logic for the drive terminals
// Contract
// (R1) Mode code 2 selects three-wire scheme; enable terminal gates running.
// (R2) Outside controller holds enable closed for as long as running is wanted.
// (R3) Rising trigger edge with enable closed starts running; level alone does not.
// (R4) At start, direction comes from direction terminal level.
// (R5) Enable opening stops drive; it is the only stop command. Code also stops on leaving mode code 2.
// (R6) While running, direction follows direction terminal changes.
// (R7) Terminals are synchronised; trigger edges ignored when open or running.
`timescale 1ns/1ps
`default_nettype none
module twr_run_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Mode setting from parameter storage, same clock domain
  input wire logic [twr_pkg::MODE_W-1:0] terminal_mode,
  // Terminals from external contacts
  input wire logic run_enable_terminal,
  input wire logic run_trigger_terminal,
  input wire logic direction_terminal,
  // Commands to the motor control
  output logic run_cmd,
  output logic reverse_cmd,
  output logic start_pulse
);
  typedef enum logic [0:0] {
    ST_STOP = 1'b0,
    ST_RUN = 1'b1
  } twr_state_t;

  typedef struct packed {
    twr_state_t fsm;
    logic trig_prev;
    logic run;
    logic reverse;
    logic start;
  } twr_ctrl_t;

  twr_ctrl_t ctrl_ff;
  twr_ctrl_t nxt_ctrl;
  logic mode_ok;
  logic rise;

  // Pin sample to command register: two synchroniser edges and the decision edge
  localparam int PIN_LAT = 3;

  // A wider mode code would never match the port, leaving the block idle for good
  if ($bits(twr_pkg::MODE_THREE_WIRE) != twr_pkg::MODE_W)
  begin : g_mode_width_check
    $error("mode code width differs from mode port width");
  end

  twr_sync_if sync_bus ();

  twr_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .run_enable_terminal(run_enable_terminal),
    .run_trigger_terminal(run_trigger_terminal),
    .direction_terminal(direction_terminal),
    .sync(sync_bus)
  );

  assign mode_ok = (terminal_mode == twr_pkg::MODE_THREE_WIRE); // [R1]
  // Edge taken on synchronised level only; a held trigger restarts only after reset
  assign rise = sync_bus.trigger_level && !ctrl_ff.trig_prev; // [R3]

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl.trig_prev = sync_bus.trigger_level;
    nxt_ctrl.start = 1'b0;
    case (ctrl_ff.fsm)
      ST_STOP:
      begin
        // Edge while enable open is dropped, not remembered
        if (mode_ok && sync_bus.enable_closed && rise) // [R3] [R7]
        begin
          nxt_ctrl.fsm = ST_RUN;
          nxt_ctrl.run = 1'b1;
          nxt_ctrl.start = 1'b1;
          nxt_ctrl.reverse = sync_bus.direction_level ? twr_pkg::DIR_REV
                                                      : twr_pkg::DIR_FWD; // [R4]
        end
      end
      ST_RUN:
      begin
        // Leaving the mode also stops, so no run survives a mode change
        if (!sync_bus.enable_closed || !mode_ok) // [R5] [R1]
        begin
          nxt_ctrl.fsm = ST_STOP;
          nxt_ctrl.run = 1'b0;
        end
        else
        begin
          nxt_ctrl.reverse = sync_bus.direction_level ? twr_pkg::DIR_REV
                                                      : twr_pkg::DIR_FWD; // [R6]
        end
      end
      default:
      begin
        nxt_ctrl.fsm = ST_STOP;
        nxt_ctrl.run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= '{fsm: ST_STOP, trig_prev: 1'b0, run: twr_pkg::RUN_RST,
                   reverse: twr_pkg::DIR_FWD, start: 1'b0};
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign run_cmd = ctrl_ff.run;
  assign reverse_cmd = ctrl_ff.reverse;
  assign start_pulse = ctrl_ff.start;

  // Assertions
  start_on_edge_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    (!ctrl_ff.run && mode_ok && sync_bus.enable_closed && rise) |=> (run_cmd && start_pulse))
    else $error("start missed after trigger edge");

  no_level_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    (!run_cmd && !rise) |=> !run_cmd)
    else $error("run began without trigger edge");

  start_dir_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    $rose(run_cmd) |-> (reverse_cmd == $past(sync_bus.direction_level)))
    else $error("start direction wrong");

  stop_on_open_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    (run_cmd && !sync_bus.enable_closed) |=> !run_cmd)
    else $error("drive kept running with enable open");

  only_stop_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    (run_cmd && sync_bus.enable_closed && mode_ok) |=> run_cmd)
    else $error("drive stopped without enable opening");

  dir_track_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    (run_cmd && sync_bus.enable_closed && mode_ok)
      |=> (reverse_cmd == $past(sync_bus.direction_level)))
    else $error("direction not tracked while running");

  mode_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    (!mode_ok && !run_cmd) |=> !run_cmd)
    else $error("run outside three-wire mode");

  edge_ignored_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    (run_cmd && rise) |=> !start_pulse)
    else $error("trigger edge acted on while running");

  sync_delay_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    $rose(run_cmd) |-> $past(run_trigger_terminal, PIN_LAT))
    else $error("start faster than synchroniser allows");

  pulse_one_cycle_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    start_pulse |=> !start_pulse)
    else $error("start pulse longer than one cycle");

  pulse_with_run_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    start_pulse |-> (run_cmd && !$past(run_cmd)))
    else $error("start pulse without a fresh run");

  pulse_needs_rise_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    start_pulse |-> $past(rise))
    else $error("start pulse without trigger edge");

  rise_needed_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    $rose(run_cmd) |-> ($past(rise) && $past(sync_bus.enable_closed)))
    else $error("run began without edge and enable");

  mode_needed_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    $rose(run_cmd) |-> $past(mode_ok))
    else $error("run began outside three-wire mode");

  mode_leave_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    (run_cmd && !mode_ok) |=> !run_cmd)
    else $error("run kept after leaving three-wire mode");

  mode_no_pulse_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    !mode_ok |=> !start_pulse)
    else $error("start taken outside three-wire mode");

  stop_cause_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    $fell(run_cmd) |-> (!$past(mode_ok) || !$past(sync_bus.enable_closed)))
    else $error("drive stopped with enable closed in mode");

  dir_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    (!run_cmd && !rise) |=> $stable(reverse_cmd))
    else $error("direction moved while stopped");

  open_no_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    !sync_bus.enable_closed |=> !start_pulse)
    else $error("start taken with enable open");

  run_no_pulse_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    run_cmd |=> !start_pulse)
    else $error("start pulse while already running");

  // Pin-level checks, PIN_LAT edges from pin sample to command
  enable_at_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    $rose(run_cmd) |-> $past(run_enable_terminal, PIN_LAT))
    else $error("start without enable closed at the pin");

  dir_at_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    $rose(run_cmd) |-> (reverse_cmd == $past(direction_terminal, PIN_LAT)))
    else $error("start direction differs from pin level");

  trig_low_first_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    ($rose(run_cmd) && $past(rst_n, PIN_LAT + 1))
      |-> !$past(run_trigger_terminal, PIN_LAT + 1))
    else $error("start without trigger low before the edge");

  open_latency_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    (run_cmd && !run_enable_terminal) |-> ##PIN_LAT !run_cmd)
    else $error("drive not stopped after enable opened");
endmodule
`default_nettype wire

// ===== verif/twr_contacts.sv
// Contact model driving the three run terminals
`timescale 1ns/1ps
`default_nettype none
module twr_contacts (
  // Clock
  input wire logic clock,
  // Wanted contact states: enable, trigger, direction
  input wire logic [2:0] want,
  // Terminals
  output logic run_enable_terminal,
  output logic run_trigger_terminal,
  output logic direction_terminal
);
  logic [2:0] held = 3'h0;
  logic [2:0] pins = 3'h0;
  // Wish taken on the rising edge so the bench's falling-edge write never races it
  always @(posedge clock)
    held <= want;
  // Contacts move off the sampling edge; enable held closed while running is wanted
  always @(negedge clock)
    pins <= held;
  assign {run_enable_terminal, run_trigger_terminal, direction_terminal} = pins;
endmodule
`default_nettype wire

// ===== verif/three_wire_run_control_tb.sv
// Self-checking bench for the three-wire run control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module three_wire_run_control_tb;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [2:0] terminal_mode = 3'h5;
  logic [2:0] want = 3'h0;
  logic en, trig, dir, run_cmd, reverse_cmd, start_pulse, d;
  logic [31:0] seed = 32'h26A7;
  logic exp_q[$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  twr_contacts u_twr_contacts (.clock(clock), .want(want), .run_enable_terminal(en),
    .run_trigger_terminal(trig), .direction_terminal(dir));
  twr_run_ctrl u_twr_run_ctrl (.clock(clock), .rst_n(rst_n), .terminal_mode(terminal_mode),
    .run_enable_terminal(en), .run_trigger_terminal(trig), .direction_terminal(dir),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .start_pulse(start_pulse));
  initial forever #20 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic go(input logic [2:0] w, input int n);
    want = w;
    repeat (n) @(negedge clock);
  endtask
  task automatic give_verdict();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Each start must carry the noted direction; a start with no note is wrong
  always @(negedge clock)
  begin
    if (rst_n && start_pulse === 1'h1)
    begin
      if (exp_q.size() == 0)
        `CHK(start_pulse, 1'h0)
      else
        `CHK(reverse_cmd, exp_q.pop_front())
    end
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (3) @(negedge clock);
    rst_n = 1'h1;
    // Other mode: a clean trigger edge must not start
    go(3'h4, 3);
    go(3'h6, 8);
    `CHK(run_cmd, 1'h0)
    go(3'h0, 4);
    terminal_mode = 3'h2;
    // Trigger edge with enable open is dropped
    go(3'h2, 8);
    `CHK(run_cmd, 1'h0)
    repeat (6)
    begin
      seed = xs(seed);
      d = seed[0];
      // Enable closing onto a high trigger is no edge
      go({2'h1, d}, 4);
      go({2'h3, d}, 8);
      `CHK(run_cmd, 1'h0)
      go({2'h2, d}, 3);
      exp_q.push_back(d);
      go({2'h3, d}, 8);
      `CHK(run_cmd, 1'h1)
      `CHK(reverse_cmd, d)
      // Retrigger while running is dropped; direction tracked
      go({2'h2, ~d}, 3);
      go({2'h3, ~d}, 8);
      `CHK(reverse_cmd, ~d)
      `CHK(run_cmd, 1'h1)
      go({2'h0, ~d}, 8);
      `CHK(run_cmd, 1'h0)
    end
    // Stopped: direction pin moves, command holds its last value
    go({2'h0, d}, 8);
    `CHK(reverse_cmd, ~d)
    // Leaving the mode stops a running drive
    exp_q.push_back(1'h0);
    go(3'h4, 4);
    go(3'h6, 8);
    `CHK(run_cmd, 1'h1)
    terminal_mode = 3'h5;
    go(3'h6, 8);
    `CHK(run_cmd, 1'h0)
    terminal_mode = 3'h2;
    go(3'h6, 4);
    `CHK(run_cmd, 1'h0)
    // Reset clears a run; a trigger held through reset counts as an edge
    go(3'h4, 4);
    exp_q.push_back(1'h0);
    go(3'h6, 8);
    `CHK(run_cmd, 1'h1)
    rst_n = 1'h0;
    go(3'h6, 3);
    `CHK(run_cmd, 1'h0)
    exp_q.push_back(1'h0);
    rst_n = 1'h1;
    go(3'h6, 8);
    `CHK(run_cmd, 1'h1)
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule
`default_nettype wire
